// ### aofc_pkg.sv
// package for the converter output format control block
// Notes on behaviour
// - stabilizer regenerates falling edge, 50% duty
// - stabilizer inactive below 20 MHz sample rate
// - unlocked stabilizer is bypassed, raw duty used
// - power-down by register bit or pin
// - power-down three-states every output driver
// - pin low wakes; wake grows with downtime
// - register standby keeps reference, faster wake
// - pin mode: format and stabilizer pins
// - register mode: binary, twos, gray formats
// - output enable bar pin three-states data
// - register 0x14 three-states each channel
// - data appears 12 sample clocks later
// - two data clocks, polarity selectable
// - 26 output bits with both channels
// - offset binary codes 000, 800, FFF
// - twos complement codes 800, 000, 7FF
package aofc_pkg;
  // register byte addresses
  localparam logic [11:0] CTRL_ADDR   = 12'h008;
  localparam logic [11:0] STAT_ADDR   = 12'h00C;
  localparam logic [11:0] OUTEN_ADDR  = 12'h014;
  // control register fields
  localparam int CTRL_REG_MODE = 0;
  localparam int CTRL_POWER_DOWN_CTRL     = 1;
  localparam int CTRL_STBY     = 2;
  localparam int CTRL_DCS      = 3;
  localparam int CTRL_FMT_LO   = 4;
  localparam int CTRL_DCO_INV  = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;
  // output enable register fields
  localparam int OUTEN_A = 0;
  localparam int OUTEN_B = 1;
  localparam logic [1:0] OUTEN_RST = 2'h0;
  // status register fields
  localparam int STAT_LOCK  = 0;
  localparam int STAT_DCSON = 1;
  localparam int STAT_RATE  = 2;
  localparam int STAT_DOWN  = 3;
  localparam int STAT_WAKE  = 4;
  // timing
  localparam int CLK_MHZ      = 40;
  localparam int DCS_MIN_MHZ  = 20;
  localparam int MIN_PER_CYC  = CLK_MHZ / DCS_MIN_MHZ;
  localparam int RELOCK_NS    = 5000;
  localparam int RELOCK_CYC   = RELOCK_NS * CLK_MHZ / 1000;
  localparam int WAKE_MAX_NS  = 10000;
  localparam int WAKE_MAX_CYC = WAKE_MAX_NS * CLK_MHZ / 1000;
  localparam int STBY_WAKE_NS = 500;
  localparam int STBY_WAKE_CYC = STBY_WAKE_NS * CLK_MHZ / 1000;
  localparam int PIPE_DEPTH   = 12;
  localparam int DW           = 12;
  // output format codes
  typedef enum logic [1:0] {
    FMT_OFFBIN,
    FMT_TWOS,
    FMT_GRAY
  } aofc_fmt_e;
  // one channel word: flag and data
  typedef struct packed {
    logic          ovr;
    logic [DW-1:0] data;
  } aofc_word_s;
  // both channels, 26 bits
  typedef struct packed {
    aofc_word_s a;
    aofc_word_s b;
  } aofc_pair_s;
  typedef enum {
    PW_RUN,
    PW_DOWN,
    PW_WAKE
  } aofc_pwr_e;
endpackage

// ### aofc_top.sv
// converter output format, power and data clock control
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module aofc_top (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // pins
  input  wire logic        smp_clk_i,
  input  wire logic        power_down_ctrl_i,
  input  wire logic        output_enable_bar_i,
  input  wire logic        format_pin_i,
  input  wire logic        stabilizer_pin_i,
  // converter core, signed lsb from midscale
  input  wire logic [12:0] core_a_i,
  input  wire logic [12:0] core_b_i,
  // outputs
  output logic [11:0]      data_a_o,
  output logic             ovr_a_o,
  output logic [11:0]      data_b_o,
  output logic             ovr_b_o,
  output logic             data_clock_out_a_o,
  output logic             data_clock_out_b_o,
  output logic             data_a_oe_n_o,
  output logic             data_b_oe_n_o,
  output logic             dco_oe_n_o
);

  typedef struct packed {
    logic [1:0]  sc;
    logic [1:0]  pd;
    logic [1:0]  output_enable_bar;
    logic [1:0]  fmt;
    logic [1:0]  duty_stabilizer;
    logic        sc_d;
    logic [7:0]  cnt;
    logic [7:0]  per;
    logic [7:0]  stab;
    logic        lock;
    logic        dclk;
    logic [6:0]  ctrl;
    logic [1:0]  outen;
    aofc_pkg::aofc_pwr_e pwr;
    logic [9:0]  down_cnt;
    logic [9:0]  wake_cnt;
    logic [aofc_pkg::PIPE_DEPTH-1:0][25:0] pipe;
    aofc_pkg::aofc_pair_s outw;
    logic        data_clock_out;
    logic        oe_a_n;
    logic        oe_b_n;
    logic        oe_c_n;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } aofc_st_s;

  aofc_st_s st_r;
  aofc_st_s st_nxt;

  // clamp and encode one core sample
  function automatic aofc_pkg::aofc_word_s fmt_word(
    input logic [12:0] v,
    input logic [1:0]  f
  );
    aofc_pkg::aofc_word_s w;
    logic [11:0] ob;
    w = '0;
    if (v[12] != v[11]) begin
      w.ovr = 1'b1;
      ob    = v[12] ? 12'h000 : 12'hFFF;
    end else begin
      ob = {~v[11], v[10:0]};
    end
    case (f)
      2'h1:    w.data = {~ob[11], ob[10:0]};
      2'h2:    w.data = ob ^ {1'b0, ob[11:1]};
      default: w.data = ob;
    endcase
    return w;
  endfunction

  logic       rise;
  logic       reg_mode;
  logic       pd_req;
  logic       stby;
  logic       dcs_en;
  logic       rate_ok;
  logic       dcs_on;
  logic [1:0] fmt_sel;
  logic       running;
  logic       setup;
  logic [31:0] rd;

  // live mode decode
  always_comb begin
    rise     = st_r.sc[1] & ~st_r.sc_d;
    reg_mode = st_r.ctrl[aofc_pkg::CTRL_REG_MODE];
    stby     = st_r.ctrl[aofc_pkg::CTRL_STBY];
    pd_req   = st_r.pd[1] | st_r.ctrl[aofc_pkg::CTRL_POWER_DOWN_CTRL] | stby;
    dcs_en   = reg_mode ? st_r.ctrl[aofc_pkg::CTRL_DCS] : st_r.duty_stabilizer[1];
    fmt_sel  = reg_mode ? st_r.ctrl[aofc_pkg::CTRL_FMT_LO +: 2] : {1'b0, st_r.fmt[1]};
    rate_ok  = (st_r.per != 8'h00) && (st_r.per <= 8'(aofc_pkg::MIN_PER_CYC));
    dcs_on   = dcs_en & st_r.lock & rate_ok;
    running  = (st_r.pwr == aofc_pkg::PW_RUN);
    setup    = psel_i & ~penable_i;
  end

  // register read mux
  always_comb begin
    rd = 32'h0000_0000;
    case (paddr_i)
      aofc_pkg::CTRL_ADDR:  rd[6:0] = st_r.ctrl;
      aofc_pkg::OUTEN_ADDR: rd[1:0] = st_r.outen;
      aofc_pkg::STAT_ADDR: begin
        rd[aofc_pkg::STAT_LOCK]  = st_r.lock;
        rd[aofc_pkg::STAT_DCSON] = dcs_on;
        rd[aofc_pkg::STAT_RATE]  = rate_ok;
        rd[aofc_pkg::STAT_DOWN]  = (st_r.pwr == aofc_pkg::PW_DOWN);
        rd[aofc_pkg::STAT_WAKE]  = (st_r.pwr == aofc_pkg::PW_WAKE);
      end
      default: rd = 32'h0000_0000;
    endcase
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    // pin synchronisers
    st_nxt.sc   = {st_r.sc[0], smp_clk_i};
    st_nxt.pd   = {st_r.pd[0], power_down_ctrl_i};
    st_nxt.output_enable_bar  = {st_r.output_enable_bar[0], output_enable_bar_i};
    st_nxt.fmt  = {st_r.fmt[0], format_pin_i};
    st_nxt.duty_stabilizer  = {st_r.duty_stabilizer[0], stabilizer_pin_i};
    st_nxt.sc_d = st_r.sc[1];

    // apb slave, one wait state
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (setup) begin
      st_nxt.prdata = 32'h0000_0000;
    end
    if (psel_i && penable_i && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      case (paddr_i)
        aofc_pkg::CTRL_ADDR: begin
          if (pwrite_i) begin
            st_nxt.ctrl = pwdata_i[6:0];
          end
        end
        aofc_pkg::OUTEN_ADDR: begin
          if (pwrite_i) begin
            st_nxt.outen = pwdata_i[1:0];
          end
        end
        aofc_pkg::STAT_ADDR: begin
          if (pwrite_i) begin
            st_nxt.pslverr = 1'b1;
          end
        end
        default: st_nxt.pslverr = 1'b1;
      endcase
      if (!pwrite_i) begin
        st_nxt.prdata = rd;
      end
    end

    // sample period measure
    if (st_r.cnt != 8'hFF) begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
    if (rise) begin
      st_nxt.cnt = 8'h01;
      st_nxt.per = st_r.cnt;
      if (st_r.cnt != st_r.per || !dcs_en) begin
        st_nxt.stab = 8'h00;
        st_nxt.lock = 1'b0;
      end
    end
    if (!dcs_en) begin
      st_nxt.stab = 8'h00;
      st_nxt.lock = 1'b0;
    end else if (!st_r.lock && !(rise && st_r.cnt != st_r.per)) begin
      if (st_r.stab == 8'(aofc_pkg::RELOCK_CYC - 1)) begin
        st_nxt.lock = 1'b1;
      end else begin
        st_nxt.stab = st_r.stab + 8'h01;
      end
    end

    // internal clock regeneration
    if (dcs_on) begin
      if (rise) begin
        st_nxt.dclk = 1'b1;
      end else if (st_r.cnt == {1'b0, st_r.per[7:1]}) begin
        st_nxt.dclk = 1'b0;
      end
    end else begin
      st_nxt.dclk = st_r.sc[1];
    end

    // power state
    case (st_r.pwr)
      aofc_pkg::PW_RUN: begin
        if (pd_req) begin
          st_nxt.pwr      = aofc_pkg::PW_DOWN;
          st_nxt.down_cnt = 10'h000;
        end
      end
      aofc_pkg::PW_DOWN: begin
        if (st_r.down_cnt != 10'(aofc_pkg::WAKE_MAX_CYC)) begin
          st_nxt.down_cnt = st_r.down_cnt + 10'h001;
        end
        if (!pd_req) begin
          st_nxt.pwr = aofc_pkg::PW_WAKE;
          if (stby) begin
            st_nxt.wake_cnt = 10'(aofc_pkg::STBY_WAKE_CYC);
          end else begin
            st_nxt.wake_cnt = st_r.down_cnt;
          end
        end
      end
      aofc_pkg::PW_WAKE: begin
        if (pd_req) begin
          st_nxt.pwr = aofc_pkg::PW_DOWN;
        end else if (st_r.wake_cnt == 10'h000) begin
          st_nxt.pwr = aofc_pkg::PW_RUN;
        end else begin
          st_nxt.wake_cnt = st_r.wake_cnt - 10'h001;
        end
      end
      default: st_nxt.pwr = aofc_pkg::PW_DOWN;
    endcase
    // standby latches wake choice until exit
    if (st_r.pwr == aofc_pkg::PW_DOWN && stby) begin
      st_nxt.down_cnt = 10'(aofc_pkg::STBY_WAKE_CYC);
    end

    if (rise && running) begin
      st_nxt.pipe[0] = {fmt_word(core_a_i, fmt_sel), fmt_word(core_b_i, fmt_sel)};
      for (int i = 1; i < aofc_pkg::PIPE_DEPTH; i++) begin
        st_nxt.pipe[i] = st_r.pipe[i-1];
      end
      st_nxt.outw = st_r.pipe[aofc_pkg::PIPE_DEPTH-1];
    end

    st_nxt.data_clock_out = st_r.dclk ^ st_r.ctrl[aofc_pkg::CTRL_DCO_INV];

    st_nxt.oe_c_n = ~running;
    st_nxt.oe_a_n = ~running | st_r.output_enable_bar[1] | st_r.outen[aofc_pkg::OUTEN_A];
    st_nxt.oe_b_n = ~running | st_r.output_enable_bar[1] | st_r.outen[aofc_pkg::OUTEN_B];
  end

  // single state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r        <= '0;
      st_r.ctrl   <= aofc_pkg::CTRL_RST;
      st_r.outen  <= aofc_pkg::OUTEN_RST;
      st_r.pwr    <= aofc_pkg::PW_RUN;
      st_r.oe_a_n <= 1'b1;
      st_r.oe_b_n <= 1'b1;
      st_r.oe_c_n <= 1'b1;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign prdata_o           = st_r.prdata;
  assign pready_o           = st_r.pready;
  assign pslverr_o          = st_r.pslverr;
  assign data_a_o           = st_r.outw.a.data;
  assign ovr_a_o            = st_r.outw.a.ovr;
  assign data_b_o           = st_r.outw.b.data;
  assign ovr_b_o            = st_r.outw.b.ovr;
  assign data_clock_out_a_o = st_r.data_clock_out;
  assign data_clock_out_b_o = st_r.data_clock_out;
  assign data_a_oe_n_o      = st_r.oe_a_n;
  assign data_b_oe_n_o      = st_r.oe_b_n;
  assign dco_oe_n_o         = st_r.oe_c_n;

endmodule // aofc_top

// ### aofc_monitor.sv
// port assertions for the converter output control block
`timescale 1ns/1ps
module aofc_monitor (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        power_down_ctrl_i,
  input wire logic        output_enable_bar_i,
  input wire logic [11:0] data_a_o,
  input wire logic        ovr_a_o,
  input wire logic        data_clock_out_a_o,
  input wire logic        data_clock_out_b_o,
  input wire logic        data_a_oe_n_o,
  input wire logic        data_b_oe_n_o,
  input wire logic        dco_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // access phase and pins held long enough to pass the synchronisers
  sequence s_acc; psel_i && penable_i && !pready_o; endsequence
  sequence s_down; power_down_ctrl_i [*6]; endsequence
  sequence s_oeb; output_enable_bar_i [*6]; endsequence
  property p_ans; s_acc |=> pready_o; endproperty
  property p_pulse; pready_o |=> !pready_o; endproperty
  property p_err; pslverr_o |-> pready_o; endproperty
  property p_req; pready_o |-> psel_i && penable_i; endproperty
  property p_down; s_down |-> data_a_oe_n_o && data_b_oe_n_o && dco_oe_n_o; endproperty
  property p_oeb; s_oeb |-> data_a_oe_n_o && data_b_oe_n_o; endproperty
  property p_clamp; ovr_a_o |-> data_a_o inside {12'h000, 12'hFFF, 12'h800, 12'h7FF}; endproperty
  property p_dco; data_clock_out_a_o == data_clock_out_b_o; endproperty
  a_ans: assert property (p_ans) else $error("no answer one cycle after access");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error flag without ready");
  a_req: assert property (p_req) else $error("ready without a request");
  a_down: assert property (p_down) else $error("drivers on in power down");
  a_oeb: assert property (p_oeb) else $error("data drivers on with enable pin high");
  a_clamp: assert property (p_clamp) else $error("flagged word not a full scale code");
  a_dco: assert property (p_dco) else $error("data clocks differ");
endmodule // aofc_monitor

bind aofc_top aofc_monitor aofc_monitor_inst (.*);

// ### aofc_capture.sv
// capture register model on the far side of the data outputs
`timescale 1ns/1ps
module aofc_capture (
  input  wire logic                 dco_i,
  input  wire logic                 oe_n_i,
  input  wire aofc_pkg::aofc_pair_s word_i,
  output aofc_pkg::aofc_pair_s      cap_o
);
  // latch all 26 bits on data clock rise, floating bus ignored
  always_ff @(posedge dco_i) begin
    if (!oe_n_i) begin
      cap_o <= word_i;
    end
  end
endmodule // aofc_capture

// ### aofc_top_tb.sv
// self-checking bench for the converter output control block
`timescale 1ns/1ps
module aofc_top_tb;
  logic                 clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, smp = 0;
  logic                 pdp = 0, oebp = 0, fmtp = 0, stbp = 0, pready, perr, dcoa, dcob, oea, output_enable_bar, oec, e;
  logic [11:0]          paddr = '0;
  logic [31:0]          pwd = '0, prd, r;
  logic [12:0]          ca = '0, cb = '0;
  aofc_pkg::aofc_pair_s wd, cap;
  int                   err_total = 0, total_checks = 0, w1, w2, w3, w4;

  aofc_top aofc_top_inst (.clk_i(clk), .arst_n_i(rst_n), .ce_i(1'b1), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready), .pslverr_o(perr),
    .smp_clk_i(smp), .power_down_ctrl_i(pdp), .output_enable_bar_i(oebp), .format_pin_i(fmtp),
    .stabilizer_pin_i(stbp), .core_a_i(ca), .core_b_i(cb), .data_a_o(wd.a.data), .ovr_a_o(wd.a.ovr),
    .data_b_o(wd.b.data), .ovr_b_o(wd.b.ovr), .data_clock_out_a_o(dcoa), .data_clock_out_b_o(dcob),
    .data_a_oe_n_o(oea), .data_b_oe_n_o(output_enable_bar), .dco_oe_n_o(oec));
  aofc_capture aofc_capture_inst (.dco_i(dcoa), .oe_n_i(oea | output_enable_bar), .word_i(wd), .cap_o(cap));

  // system clock and free running sample clock of unrelated phase
  initial forever #12.5 clk = ~clk;
  initial begin
    #37;
    forever #100 smp = ~smp;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one apb transfer, waits for ready, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk) pen <= 1;
    n = 0;
    // ready is looked at while settled, then taken at the following rising edge
    do begin @(negedge clk); n++; end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin err_total++; tally_and_finish; end
    @(posedge clk);
    r = prd;
    e = perr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  // expected flag and word from a signed core value
  function automatic logic [12:0] xp(input logic [12:0] v, input logic [1:0] f);
    logic [11:0] o;
    logic        ov;
    ov = v[12] != v[11];
    o = ov ? {12{~v[12]}} : v[11:0] ^ 12'h800;
    if (f == 2'h1) o = o ^ 12'h800;
    if (f == 2'h2) o = o ^ (o >> 1);
    return {ov, o};
  endfunction
  // boundary values through both channels, 16 sample periods each
  task automatic run(input logic [1:0] f);
    logic [12:0] t [6] = '{13'h1800, 13'h0000, 13'h07FF, 13'h0834, 13'h17CC, 13'h0001};
    foreach (t[i]) begin
      ca <= t[i];
      cb <= -t[i];
      repeat (128) @(posedge clk);
      chk(cap.a, xp(t[i], f));
      chk(cap.b, xp(-t[i], f));
    end
  endtask
  // power down by pin (c zero) or control word, returns wake cycles
  task automatic pd(input logic [31:0] c, input int hold, output int w);
    if (c == 0) pdp <= 1;
    else apb(1, 12'h008, c);
    repeat (hold) @(posedge clk);
    chk({oea, output_enable_bar, oec}, 3'h7);
    if (c == 0) pdp <= 0;
    else apb(1, 12'h008, 0);
    w = 0;
    while (oec !== 1'b0 && w < 1000) begin @(posedge clk); w++; end
    if (w >= 1000) begin err_total++; tally_and_finish; end
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, 12'h008, 0);
    chk(r, 0);
    apb(0, 12'h014, 0);
    chk(r, 0);
    apb(0, 12'h010, 0);
    chk({e, r}, 33'h1_0000_0000);
    apb(1, 12'h00C, 32'h1F);
    chk(e, 1);
    apb(1, 12'h008, 32'h69);
    apb(0, 12'h008, 0);
    chk(r, 32'h69);
    stbp <= 1;
    apb(0, 12'h00C, 0);
    chk(r[2:0], 3'h0);
    apb(1, 12'h008, 32'h09);
    // host waits out the relock time at a steady sample rate
    repeat (aofc_pkg::RELOCK_CYC + 16) @(posedge clk);
    apb(0, 12'h00C, 0);
    chk(r[2:0], 3'h1);
    $display("registers done");
    for (int f = 0; f < 3; f++) begin
      apb(1, 12'h008, 32'h1 | (f << 4));
      run(f[1:0]);
    end
    apb(1, 12'h008, 0);
    for (int p = 1; p >= 0; p--) begin
      fmtp <= p[0];
      run({1'b0, p[0]});
    end
    $display("formats done");
    apb(1, 12'h014, 1);
    repeat (4) @(posedge clk);
    chk({oea, output_enable_bar}, 2'h2);
    apb(1, 12'h014, 0);
    oebp <= 1;
    repeat (6) @(posedge clk);
    chk({oea, output_enable_bar}, 2'h3);
    oebp <= 0;
    repeat (6) @(posedge clk);
    chk({oea, output_enable_bar}, 2'h0);
    pd(0, 40, w1);
    pd(0, 200, w2);
    chk(w1 < w2, 1);
    pd(2, 200, w3);
    pd(4, 200, w4);
    chk(w4 < w3, 1);
    $display("power done");
    tally_and_finish;
  end
endmodule // aofc_top_tb
